// File: verilog/tvr_recorder.sv
`timescale 1ns/1ps
`default_nettype none

module tvr_recorder #(
    parameter int CLK_PER_SMP = tvr_pkg::CLK_HZ / tvr_pkg::SAMPLE_HZ
) (
    input  wire logic                                        core_clk,
    input  wire logic                                        sys_rst,
    input  wire logic                                        pickup_capture_input,
    input  wire logic                                        report_trigger_input,
    input  wire logic [tvr_pkg::NUM_CH*tvr_pkg::SAMPLE_W-1:0] sample_data,
    input  wire logic [tvr_pkg::NUM_CH*tvr_pkg::SCALE_W-1:0]  ratio_data,
    input  wire tvr_pkg::tvr_src_t [tvr_pkg::NUM_CH-1:0]      chan_src,
    output var  tvr_pkg::tvr_event_t                         event_out
);
    import tvr_pkg::*;

    // the pointer wraps by width, so the depth must be a full power of two
    if (CLK_PER_SMP < 2 || HIST_DEPTH != (1 << HIST_AW)
        || HIST_DEPTH <= PREFAULT_SMP + FAULT_B_SMP)
    begin : g_bad_cfg
        $error("tvr_recorder: unsupported sample divider or history depth");
    end

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_CAPTURE = 4'b0010,
        ST_ARMED   = 4'b0100,
        ST_REPORT  = 4'b1000
    } tvr_state_t;

    localparam int DIV_W = $clog2(CLK_PER_SMP + 1);
    localparam logic [HIST_AW-1:0] PRE_OFS = HIST_AW'(PREFAULT_SMP);
    localparam logic [7:0] CNT_A = 8'(FAULT_A_SMP);
    localparam logic [7:0] CNT_B = 8'(FAULT_B_SMP);

    // source kind only chooses sign handling: calculated values are magnitudes
    function automatic logic [VALUE_W-1:0] to_primary(input logic [SAMPLE_W-1:0] s,
                                                      input logic [SCALE_W-1:0] r,
                                                      input tvr_src_t k);
        logic signed [VALUE_W-1:0] sx;
        sx = (k == TVR_SRC_CALC) ? $signed({16'h0000, s}) : VALUE_W'($signed(s));
        return VALUE_W'(sx * $signed({16'h0000, r}));
    endfunction

    logic [1:0] start_sync_reg;
    logic [1:0] trip_sync_reg;
    logic       start_prev_reg;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            start_sync_reg <= 2'h0;
            trip_sync_reg  <= 2'h0;
            start_prev_reg <= 1'b0;
        end
        else
        begin
            start_sync_reg <= {start_sync_reg[0], pickup_capture_input};
            trip_sync_reg  <= {trip_sync_reg[0], report_trigger_input};
            start_prev_reg <= start_sync_reg[1];
        end
    end
    logic start_rise;
    logic trip_level;
    assign start_rise = start_sync_reg[1] & ~start_prev_reg;
    assign trip_level = trip_sync_reg[1];

    logic [DIV_W-1:0] div_reg;
    logic             smp_tick;
    assign smp_tick = (div_reg == DIV_W'(CLK_PER_SMP - 1));
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            div_reg <= '0;
        else if (smp_tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + DIV_W'(1);
    end

    // history of primary values per channel
    logic [VALUE_W-1:0] hist_mem [NUM_CH][HIST_DEPTH];
    logic [HIST_AW-1:0] wr_ptr_reg;
    logic [VALUE_W-1:0] cur_val [NUM_CH];
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            wr_ptr_reg <= '0;
        else if (smp_tick)
            wr_ptr_reg <= wr_ptr_reg + HIST_AW'(1);
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_hist
            assign cur_val[g] = to_primary(sample_data[g*SAMPLE_W +: SAMPLE_W],
                                           ratio_data[g*SCALE_W +: SCALE_W],
                                           chan_src[g]);
            always_ff @(posedge core_clk)
            begin
                if (smp_tick)
                    hist_mem[g][wr_ptr_reg] <= cur_val[g];
            end
        end
    endgenerate

    tvr_state_t         state_reg;
    logic [7:0]         smp_cnt_reg;
    logic               done_reg;
    logic [VALUE_W-1:0] pre_reg [NUM_CH];
    logic [VALUE_W-1:0] fa_reg  [NUM_CH];
    logic [VALUE_W-1:0] fault_reg [NUM_CH];
    logic [1:0]         rep_ch_reg;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg   <= ST_IDLE;
            smp_cnt_reg <= 8'h00;
            done_reg    <= 1'b0;
            rep_ch_reg  <= 2'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start_rise)
                    begin
                        state_reg   <= ST_CAPTURE;
                        smp_cnt_reg <= 8'h00;
                        done_reg    <= 1'b0;
                    end
                end
                ST_CAPTURE, ST_ARMED:
                begin
                    if (start_rise)
                    begin
                        state_reg   <= ST_CAPTURE;
                        smp_cnt_reg <= 8'h00;
                        done_reg    <= 1'b0;
                    end
                    else
                    begin
                        if (smp_tick && !done_reg)
                        begin
                            smp_cnt_reg <= smp_cnt_reg + 8'h01;
                            if (smp_cnt_reg + 8'h01 == CNT_B)
                            begin
                                done_reg  <= 1'b1;
                                state_reg <= ST_ARMED;
                            end
                        end
                        // an early trip waits in capture until done
                        if (trip_level && done_reg)
                        begin
                            state_reg  <= ST_REPORT;
                            rep_ch_reg <= 2'h0;
                        end
                    end
                end
                ST_REPORT:
                begin
                    if (rep_ch_reg == 2'(NUM_CH - 1))
                    begin
                        state_reg <= ST_IDLE;
                        done_reg  <= 1'b0;
                    end
                    rep_ch_reg <= rep_ch_reg + 2'h1;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // pointer of the sample taken 100 ms before start, read at the start edge
    logic [HIST_AW-1:0] pre_idx;
    assign pre_idx = wr_ptr_reg - PRE_OFS;

    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_cap
            logic [VALUE_W:0] sum;
            assign sum = {fa_reg[g][VALUE_W-1], fa_reg[g]} + {cur_val[g][VALUE_W-1], cur_val[g]};
            always_ff @(posedge core_clk)
            begin
                if (sys_rst || (state_reg == ST_REPORT && rep_ch_reg == 2'(NUM_CH - 1)))
                begin
                    pre_reg[g]   <= '0;
                    fa_reg[g]    <= '0;
                    fault_reg[g] <= '0;
                end
                // a start during the report must not change values still being sent
                else if (start_rise && state_reg != ST_REPORT)
                    pre_reg[g] <= hist_mem[g][pre_idx];
                else if (smp_tick && !done_reg && state_reg == ST_CAPTURE)
                begin
                    if (smp_cnt_reg + 8'h01 == CNT_A)
                        fa_reg[g] <= cur_val[g];
                    if (smp_cnt_reg + 8'h01 == CNT_B)
                        fault_reg[g] <= sum[VALUE_W:1];
                end
            end
        end
    endgenerate

    // the event word is the block's only result; no binary outputs exist
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            event_out <= '0;
        else if (state_reg == ST_REPORT)
        begin
            event_out.valid    <= 1'b1;
            event_out.channel  <= rep_ch_reg;
            event_out.prefault <= pre_reg[rep_ch_reg];
            event_out.fault    <= fault_reg[rep_ch_reg];
        end
        else
            event_out <= '0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_report_burst;
        event_out.valid [*3];
    endsequence

    property p_no_event_idle;
        state_reg == ST_IDLE && !$past(state_reg == ST_REPORT) |-> !event_out.valid;
    endproperty
    a_no_event_idle: assert property (p_no_event_idle) else $error("event without report");

    property p_report_three;
        $rose(event_out.valid) |-> s_report_burst ##1 !event_out.valid;
    endproperty
    a_report_three: assert property (p_report_three) else $error("report not three events");

    property p_report_needs_done;
        state_reg == ST_REPORT && $past(state_reg) != ST_REPORT |-> $past(done_reg);
    endproperty
    a_report_needs_done: assert property (p_report_needs_done) else $error("early report");

    property p_start_restarts;
        start_rise && state_reg != ST_REPORT |=> state_reg == ST_CAPTURE && smp_cnt_reg == 8'h00;
    endproperty
    a_start_restarts: assert property (p_start_restarts) else $error("start not restarting");

    property p_channel_order;
        $rose(event_out.valid) |-> event_out.channel == 2'h0 ##1 event_out.channel == 2'h1
            ##1 event_out.channel == 2'h2;
    endproperty
    a_channel_order: assert property (p_channel_order) else $error("channel order wrong");

    property p_clear_after;
        $past(state_reg == ST_REPORT) && state_reg == ST_IDLE
            |-> pre_reg[0] == '0 && fa_reg[0] == '0 && fault_reg[0] == '0;
    endproperty
    a_clear_after: assert property (p_clear_after) else $error("values not cleared");

    property p_trip_reports;
        state_reg == ST_ARMED && trip_level && !start_rise |=> state_reg == ST_REPORT;
    endproperty
    a_trip_reports: assert property (p_trip_reports) else $error("trip ignored");

    property p_done_count;
        $rose(done_reg) |-> smp_cnt_reg == CNT_B;
    endproperty
    a_done_count: assert property (p_done_count) else $error("fault capture count wrong");

endmodule

`default_nettype wire

// File: inc/tvr_pkg.sv
package tvr_pkg;

    localparam int NUM_CH        = 3;
    localparam int SAMPLE_W      = 16;
    localparam int VALUE_W       = 32;
    localparam int SCALE_W       = 16;
    // analog sample rate and clock rate
    localparam int CLK_HZ        = 100_000_000;
    localparam int SAMPLE_HZ     = 1000;
    localparam int MS_PER_S      = 1000;
    // capture instants, in ms
    localparam int PREFAULT_MS   = 100;
    localparam int FAULT_A_MS    = 10;
    localparam int FAULT_B_MS    = 20;
    localparam int PREFAULT_SMP  = (PREFAULT_MS * SAMPLE_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam int FAULT_A_SMP   = (FAULT_A_MS * SAMPLE_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam int FAULT_B_SMP   = (FAULT_B_MS * SAMPLE_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam int HIST_DEPTH    = 128;
    localparam int HIST_AW       = 7;

    // channel source kinds
    typedef enum logic [1:0] {
        TVR_SRC_CURRENT = 2'h0,
        TVR_SRC_VOLTAGE = 2'h1,
        TVR_SRC_CALC    = 2'h2
    } tvr_src_t;

    typedef struct packed {
        logic                   valid;
        logic [1:0]             channel;
        logic [VALUE_W-1:0]     prefault;
        logic [VALUE_W-1:0]     fault;
    } tvr_event_t;

endpackage

// File: bench/tvr_prot_model.sv
`timescale 1ns/1ps
`default_nettype none

module tvr_prot_model (
    input  wire logic                                          core_clk,
    input  wire logic                                          clr,
    input  wire logic                                          start_req,
    input  wire logic                                          trip_req,
    input  wire logic [tvr_pkg::NUM_CH*tvr_pkg::SAMPLE_W-1:0]  lvl,
    input  wire tvr_pkg::tvr_event_t                           event_out,
    output logic                                               pickup_capture_input,
    output logic                                               report_trigger_input,
    output logic [tvr_pkg::NUM_CH*tvr_pkg::SAMPLE_W-1:0]       sample_data,
    output int                                                 n_ev,
    output logic [1:0]                                         ev_ch [4],
    output logic [31:0]                                        ev_pre [4],
    output logic [31:0]                                        ev_flt [4]
);
    import tvr_pkg::*;

    // general pickup and general trip are plain levels from protection logic
    always @(posedge core_clk)
    begin
        pickup_capture_input <= start_req;
        report_trigger_input <= trip_req;
        sample_data          <= lvl;
    end

    // event list: keeps a fourth entry so a stray extra event is seen
    always @(posedge core_clk)
    begin
        if (clr)
            n_ev <= 0;
        else if (event_out.valid && n_ev < 4)
        begin
            ev_ch[n_ev]  <= event_out.channel;
            ev_pre[n_ev] <= event_out.prefault;
            ev_flt[n_ev] <= event_out.fault;
            n_ev         <= n_ev + 1;
        end
    end
endmodule

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import tvr_pkg::*;

    localparam int CPS = 10;
    typedef tvr_src_t [NUM_CH-1:0] tvr_srcv_t;
    typedef struct packed {
        logic [5:0]  src;
        logic [47:0] ratio;
        logic [47:0] q;
        logic [47:0] p;
        logic [47:0] a;
        logic [47:0] b;
        logic [95:0] e_pre;
        logic [95:0] e_flt;
    } tvr_row_t;

    logic        core_clk;
    logic        sys_rst;
    logic        clr;
    logic        start_req;
    logic        trip_req;
    logic [47:0] lvl;
    logic [47:0] ratio_data;
    tvr_srcv_t   chan_src;
    logic        pickup_capture_input;
    logic        report_trigger_input;
    logic [47:0] sample_data;
    tvr_event_t  event_out;
    int          n_ev;
    logic [1:0]  ev_ch [4];
    logic [31:0] ev_pre [4];
    logic [31:0] ev_flt [4];
    tvr_row_t    rows [3];
    int          n_mismatch;
    int          compares;

    tvr_recorder #(.CLK_PER_SMP(CPS)) u_tvr_recorder (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pickup_capture_input(pickup_capture_input),
        .report_trigger_input(report_trigger_input),
        .sample_data(sample_data), .ratio_data(ratio_data),
        .chan_src(chan_src), .event_out(event_out));

    tvr_prot_model u_tvr_prot_model (
        .core_clk(core_clk), .clr(clr), .start_req(start_req), .trip_req(trip_req),
        .lvl(lvl), .event_out(event_out),
        .pickup_capture_input(pickup_capture_input),
        .report_trigger_input(report_trigger_input),
        .sample_data(sample_data), .n_ev(n_ev),
        .ev_ch(ev_ch), .ev_pre(ev_pre), .ev_flt(ev_flt));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n * CPS) @(posedge core_clk);
    endtask

    // outputs are read at the falling edge, where they have settled
    task automatic wait_report(input tvr_row_t r);
        int i;
        i = 0;
        while (n_ev < 3 && i < 600)
        begin
            @(posedge core_clk);
            i++;
        end
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        cmp_val(32'(n_ev), 32'h0000_0003);
        cmp_val({31'h0, event_out.valid}, 32'h0000_0000);
        cmp_val(event_out.prefault | event_out.fault, 32'h0000_0000);
        for (i = 0; i < 3; i++)
        begin
            cmp_val({30'h0, ev_ch[i]}, 32'(i));
            cmp_val(ev_pre[i], r.e_pre[32*i+:32]);
            cmp_val(ev_flt[i], r.e_flt[32*i+:32]);
        end
        @(posedge core_clk);
    endtask

    // mode 1 restarts before any trip, mode 2 trips while capture runs
    task automatic run_case(input tvr_row_t r, input int mode);
        @(posedge core_clk);
        chan_src <= tvr_srcv_t'(r.src);
        ratio_data <= r.ratio;
        lvl <= r.q;
        clr <= 1'b1;
        ticks(20);
        lvl <= r.p;
        clr <= 1'b0;
        if (mode == 1)
        begin
            ticks(5);
            start_req <= 1'b1;
            ticks(30);
            start_req <= 1'b0;
            ticks(75);
        end
        else
            ticks(110);
        start_req <= 1'b1;
        lvl <= r.a;
        ticks(15);
        lvl <= r.b;
        if (mode == 2)
        begin
            trip_req <= 1'b1;
            ticks(3);
            cmp_val(32'(n_ev), 32'h0000_0000);
        end
        else
            ticks(10);
        trip_req <= 1'b1;
        wait_report(r);
        start_req <= 1'b0;
        trip_req <= 1'b0;
    endtask

    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        sys_rst = 1'b1;
        clr = 1'b1;
        start_req = 1'b0;
        trip_req = 1'b0;
        lvl = '0;
        ratio_data = '0;
        chan_src = tvr_srcv_t'(6'h00);
        n_mismatch = 0;
        compares = 0;
        rows[0] = '{6'h24, 48'h0003_0002_0001, 48'h0111_0111_0111, 48'h8000_0200_0100,
                    48'h0030_0020_0010, 48'h0050_0040_0030,
                    96'h0001_8000_0000_0400_0000_0100, 96'h0000_00C0_0000_0060_0000_0020};
        rows[1] = '{6'h09, 48'h0064_000A_0005, 48'h0222_0222_0222, 48'h0007_0006_0005,
                    48'hFFFC_1000_0040, 48'hFFF8_2000_0060,
                    96'h0000_02BC_0000_003C_0000_0019, 96'hFFFF_FDA8_0000_F000_0000_0190};
        rows[2] = '{6'h12, 48'h1000_0100_0010, 48'h0333_0333_0333, 48'h0001_FFFE_FFFF,
                    48'h0002_0004_0006, 48'h0004_0008_000A,
                    96'h0000_1000_FFFF_FE00_000F_FFF0, 96'h0000_3000_0000_0600_0000_0080};
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        cmp_val({31'h0, event_out.valid}, 32'h0000_0000);
        for (int i = 0; i < 3; i++)
            run_case(rows[i], 0);
        run_case(rows[0], 1);
        run_case(rows[1], 2);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        trip_req <= 1'b1;
        ticks(30);
        cmp_val(32'(n_ev), 32'h0000_0000);
        // reset while armed must drop the capture, so a later trip reports nothing
        trip_req <= 1'b0;
        start_req <= 1'b1;
        ticks(25);
        sys_rst <= 1'b1;
        start_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        trip_req <= 1'b1;
        ticks(5);
        cmp_val(32'(n_ev), 32'h0000_0000);
        final_report();
    end
endmodule

`default_nettype wire
